/* design/ptfc_pkg.sv */
// Purpose: Shared constants and types for the target link controller and its initiator.
// Assumes: One system clock of 40 MHz on both ends; 32-bit data.
// Notes: Register offsets are byte addresses on the APB side of the target.
package ptfc_pkg;
  // Register byte offsets.
  localparam logic [7:0] REG_TCTL = 8'h00;
  localparam logic [7:0] REG_TBL = 8'h04;
  localparam logic [7:0] REG_IO_SIZE = 8'h08;
  localparam logic [7:0] REG_IO_BASE = 8'h0c;
  localparam logic [7:0] REG_MEM_SIZE = 8'h10;
  localparam logic [7:0] REG_MEM_BASE = 8'h14;
  localparam logic [7:0] REG_CFG = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1c;
  // Field positions in the target control register.
  localparam int B_CACHE_DIS = 19;
  localparam int B_SB_DIS = 18;
  localparam int B_OB_OPT = 17;
  localparam int B_FD_SEL = 16;
  localparam int B_IN8 = 15;
  localparam int B_OUT8 = 14;
  localparam int B_OUT_RSV = 13;
  localparam int B_IN_RSV = 12;
  localparam int TBL_LSB = 4;
  // Values after reset.
  localparam logic [31:0] TCTL_RST = 32'h000c_c000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // The reserved tail of every window is four doublewords.
  localparam logic [31:0] RSV_TAIL_BYTES = 32'h0000_0010;
  // Timing: link edges and clock rates.
  localparam int FIRST_DATA_EDGES = 16;
  localparam int MABORT_EDGES = 32;
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // Link commands.
  typedef enum logic [1:0] {
    CMD_MEM_RD = 2'h0,
    CMD_MEM_WR = 2'h1,
    CMD_IO_WR = 2'h2,
    CMD_CFG_WR = 2'h3
  } ptfc_cmd_type;
  // Ending of a transfer as seen by the initiator.
  typedef enum logic [1:0] {
    END_OK = 2'h0,
    END_RETRY = 2'h1,
    END_TABORT = 2'h2,
    END_MABORT = 2'h3
  } ptfc_end_type;
endpackage : ptfc_pkg

/* design/ptfc_link_if.sv */
// Purpose: Carrier of the target link between initiator and target.
// Assumes: The initiator makes the link clock; each end samples every signal that the other end drives.
// Notes: Request is held until a response shows; response held until frame falls.
`timescale 1ns/1ps
interface ptfc_link_if;
  logic link_clk;
  logic frame;
  logic [1:0] cmd;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic trdy;
  logic stop;
  logic tabort;
  modport target (input link_clk, frame, cmd, addr, wdata,
                  output rdata, trdy, stop, tabort);
  modport initiator (output link_clk, frame, cmd, addr, wdata,
                     input rdata, trdy, stop, tabort);
endinterface : ptfc_link_if

/* design/ptfc_target.sv */
// Purpose: Target end of the link: window decode, retry policy, queues, APB registers.
// Assumes: Link inputs are asynchronous; the link clock is sampled, not used as clock.
// Notes: APB answers with one wait state; unmapped offsets give pslverr.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module ptfc_target #(
  parameter int first_data_edges = ptfc_pkg::FIRST_DATA_EDGES
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic ob_valid_in,
  input wire logic [31:0] ob_data_in,
  output logic ob_ready_out,
  output logic ib_valid_out,
  output logic [31:0] ib_data_out,
  input wire logic ib_ready_in,
  ptfc_link_if.target lnk
);
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_WAIT = 2'h1,
    S_ANSWER = 2'h2,
    S_HOLD = 2'h3
  } ptfc_tst_type;

  // The edge counter must be able to reach its limit.
  if (first_data_edges < 1 || first_data_edges > 255) begin : g_bad_edges
    $error("first_data_edges out of range");
  end

  logic [31:0] tctl, target_burst_length, io_size, io_base, mem_size, mem_base, cfg;
  logic [31:0] next_tctl, next_tbl, next_io_size, next_io_base;
  logic [31:0] next_mem_size, next_mem_base, next_cfg;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [67:0] s1, s2, s3, filt, next_filt;
  logic lclk_prev;
  ptfc_tst_type st, next_st;
  logic [31:0] sh_tctl, next_sh_tctl;
  logic [7:0] cnt, next_cnt;
  logic [2:0] pend, next_pend, resp, next_resp;
  logic [31:0] rdata, next_rdata;
  logic ob_valid, next_ob_valid;
  logic [31:0] ob_data, next_ob_data;
  logic [31:0] ib_mem [0:1];
  logic [31:0] next_ib_mem [0:1];
  logic ib_wp, ib_rp, next_ib_wp, next_ib_rp;
  logic [1:0] ib_cnt, next_ib_cnt;
  logic link_edge, f_frame;
  logic [1:0] f_cmd;
  logic [31:0] f_addr, f_wdata;
  logic cfg_wr, ib_push, ob_give;
  logic conflict;
  logic apb_wr;

  // Three-stage sampling; a bit changes once stages two and three agree.
  assign next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
  assign f_frame = filt[66];
  assign f_cmd = filt[65:64];
  assign f_addr = filt[63:32];
  assign f_wdata = filt[31:0];
  assign link_edge = filt[67] & ~lclk_prev;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
      lclk_prev <= 1'b0;
    end else begin
      s1 <= {lnk.link_clk, lnk.frame, lnk.cmd, lnk.addr, lnk.wdata};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      lclk_prev <= filt[67];
    end
  end

  // Software writes on the edge at which pready is seen high.
  assign apb_wr = psel_in & penable_in & pready_out & pwrite_in;

  // Misconfigurations that software must avoid are reported, not corrected.
  always_comb begin
    conflict = 1'b0;
    if (!tctl[ptfc_pkg::B_CACHE_DIS] && !tctl[ptfc_pkg::B_SB_DIS]) begin
      conflict = 1'b1;
    end
    // A sixteen-doubleword burst clashes with the option bit and with bit 18 alike.
    if ((target_burst_length[7:6] == 2'b01 || (target_burst_length[7] && target_burst_length[5])) &&
        (tctl[ptfc_pkg::B_OB_OPT] || tctl[ptfc_pkg::B_SB_DIS])) begin
      conflict = 1'b1;
    end
    if (!tctl[ptfc_pkg::B_IN8] || !tctl[ptfc_pkg::B_OUT8]) begin
      conflict = 1'b1;
    end
  end

  // Register file and APB read path.
  always_comb begin
    next_tctl = tctl;
    next_tbl = target_burst_length;
    next_io_size = io_size;
    next_io_base = io_base;
    next_mem_size = mem_size;
    next_mem_base = mem_base;
    next_cfg = cfg;
    next_pready = psel_in & penable_in & ~pready_out;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (cfg_wr) begin
      next_cfg = f_wdata;
    end
    if (apb_wr) begin
      if (paddr_in == ptfc_pkg::REG_TCTL) begin
        next_tctl = pwdata_in;
      end else if (paddr_in == ptfc_pkg::REG_TBL) begin
        next_tbl = {24'h000000, pwdata_in[7:0]};
      end else if (paddr_in == ptfc_pkg::REG_IO_SIZE) begin
        next_io_size = pwdata_in;
      end else if (paddr_in == ptfc_pkg::REG_IO_BASE) begin
        next_io_base = pwdata_in;
      end else if (paddr_in == ptfc_pkg::REG_MEM_SIZE) begin
        next_mem_size = pwdata_in;
      end else if (paddr_in == ptfc_pkg::REG_MEM_BASE) begin
        next_mem_base = pwdata_in;
      end else if (paddr_in == ptfc_pkg::REG_CFG) begin
        next_cfg = pwdata_in;
      end
    end
    if (next_pready) begin
      if (paddr_in == ptfc_pkg::REG_TCTL) begin
        next_prdata = tctl;
      end else if (paddr_in == ptfc_pkg::REG_TBL) begin
        next_prdata = target_burst_length;
      end else if (paddr_in == ptfc_pkg::REG_IO_SIZE) begin
        next_prdata = io_size;
      end else if (paddr_in == ptfc_pkg::REG_IO_BASE) begin
        next_prdata = io_base;
      end else if (paddr_in == ptfc_pkg::REG_MEM_SIZE) begin
        next_prdata = mem_size;
      end else if (paddr_in == ptfc_pkg::REG_MEM_BASE) begin
        next_prdata = mem_base;
      end else if (paddr_in == ptfc_pkg::REG_CFG) begin
        next_prdata = cfg;
      end else if (paddr_in == ptfc_pkg::REG_STAT) begin
        next_prdata = {26'h0000000, conflict, st != S_IDLE, ob_valid, 1'b0, ib_cnt};
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tctl <= ptfc_pkg::TCTL_RST;
      target_burst_length <= ptfc_pkg::WORD_RST;
      io_size <= ptfc_pkg::WORD_RST;
      io_base <= ptfc_pkg::WORD_RST;
      mem_size <= ptfc_pkg::WORD_RST;
      mem_base <= ptfc_pkg::WORD_RST;
      cfg <= ptfc_pkg::WORD_RST;
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      tctl <= next_tctl;
      target_burst_length <= next_tbl;
      io_size <= next_io_size;
      io_base <= next_io_base;
      mem_size <= next_mem_size;
      mem_base <= next_mem_base;
      cfg <= next_cfg;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end

  // Window decode. A base written before its size decodes against a stale mask.
  logic mem_hit, io_hit, mem_rsv, io_rsv;
  assign mem_hit = (mem_size != 32'h0) && ((f_addr & ~(mem_size - 32'h1)) == mem_base);
  assign io_hit = (io_size != 32'h0) && ((f_addr & ~(io_size - 32'h1)) == io_base);
  assign mem_rsv = (f_addr & (mem_size - 32'h1)) >= (mem_size - ptfc_pkg::RSV_TAIL_BYTES);
  assign io_rsv = (f_addr & (io_size - 32'h1)) >= (io_size - ptfc_pkg::RSV_TAIL_BYTES);

  // Transaction machine. Pend holds {tabort, stop, trdy} for the next answer.
  always_comb begin
    next_st = st;
    next_sh_tctl = sh_tctl;
    next_cnt = cnt;
    next_pend = pend;
    next_resp = resp;
    next_rdata = rdata;
    cfg_wr = 1'b0;
    ib_push = 1'b0;
    ob_give = 1'b0;
    case (st)
      S_IDLE: begin
        next_sh_tctl = tctl;
        if (link_edge && f_frame) begin
          next_st = S_ANSWER;
          if (f_cmd == ptfc_pkg::CMD_CFG_WR) begin
            cfg_wr = 1'b1;
            next_pend = 3'b001;
          end else if (f_cmd == ptfc_pkg::CMD_MEM_RD && mem_hit) begin
            if (mem_rsv && !sh_tctl[ptfc_pkg::B_OUT_RSV]) begin
              next_pend = 3'b100;
            end else if (ob_valid) begin
              ob_give = 1'b1;
            end else if (sh_tctl[ptfc_pkg::B_FD_SEL]) begin
              next_st = S_WAIT;
              next_cnt = 8'h00;
            end else begin
              next_pend = 3'b010;
            end
          end else if ((f_cmd == ptfc_pkg::CMD_MEM_WR && mem_hit) ||
                       (f_cmd == ptfc_pkg::CMD_IO_WR && io_hit)) begin
            if (((f_cmd == ptfc_pkg::CMD_MEM_WR) ? mem_rsv : io_rsv) &&
                !sh_tctl[ptfc_pkg::B_IN_RSV]) begin
              next_pend = 3'b100;
            end else if (ib_cnt != 2'h2) begin
              ib_push = 1'b1;
              next_pend = {1'b0, ~sh_tctl[ptfc_pkg::B_IN8], 1'b1};
            end else begin
              next_pend = 3'b010;
            end
          end else begin
            next_st = S_IDLE; // No claim: the initiator ends it by master-abort.
          end
        end
      end
      S_WAIT: begin
        if (ob_valid) begin
          ob_give = 1'b1;
          next_st = S_ANSWER;
        end else if (link_edge) begin
          next_cnt = cnt + 8'h01;
          if (cnt == 8'(first_data_edges - 1)) begin
            next_pend = 3'b010;
            next_st = S_ANSWER;
          end
        end
      end
      S_ANSWER: begin
        next_resp = pend;
        next_st = S_HOLD;
      end
      S_HOLD: begin
        if (link_edge && !f_frame) begin
          next_resp = 3'b000;
          next_st = S_IDLE;
        end
      end
      default: begin
        next_st = S_IDLE;
      end
    endcase
    if (ob_give) begin
      next_rdata = ob_data;
      // Disconnect with data when single burst is on or the eight-word option is off.
      next_pend = {1'b0, ~sh_tctl[ptfc_pkg::B_SB_DIS] | ~sh_tctl[ptfc_pkg::B_OUT8],
                   1'b1};
    end
  end

  // Outbound entry: a cached entry is served again until a read with caching disabled consumes it.
  always_comb begin
    next_ob_valid = ob_valid;
    next_ob_data = ob_data;
    if (ob_give && sh_tctl[ptfc_pkg::B_CACHE_DIS]) begin
      next_ob_valid = 1'b0;
    end
    if (ob_valid_in && ob_ready_out) begin
      next_ob_valid = 1'b1;
      next_ob_data = ob_data_in;
    end
  end

  // Two-entry inbound buffer; a full buffer turns link writes into retries.
  logic ib_pop;
  assign ib_pop = ib_valid_out & ib_ready_in;
  always_comb begin
    next_ib_mem = ib_mem;
    next_ib_wp = ib_wp;
    next_ib_rp = ib_rp;
    next_ib_cnt = ib_cnt;
    if (ib_push) begin
      next_ib_mem[ib_wp] = f_wdata;
      next_ib_wp = ~ib_wp;
    end
    if (ib_pop) begin
      next_ib_rp = ~ib_rp;
    end
    next_ib_cnt = ib_cnt + {1'b0, ib_push} - {1'b0, ib_pop};
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= S_IDLE;
      sh_tctl <= ptfc_pkg::TCTL_RST;
      cnt <= 8'h00;
      pend <= 3'b000;
      resp <= 3'b000;
      rdata <= 32'h0000_0000;
      ob_valid <= 1'b0;
      ob_data <= 32'h0000_0000;
      ob_ready_out <= 1'b0;
      ib_mem[0] <= 32'h0000_0000;
      ib_mem[1] <= 32'h0000_0000;
      ib_wp <= 1'b0;
      ib_rp <= 1'b0;
      ib_cnt <= 2'h0;
      ib_valid_out <= 1'b0;
      ib_data_out <= 32'h0000_0000;
    end else begin
      st <= next_st;
      sh_tctl <= next_sh_tctl;
      cnt <= next_cnt;
      pend <= next_pend;
      resp <= next_resp;
      rdata <= next_rdata;
      ob_valid <= next_ob_valid;
      ob_data <= next_ob_data;
      ob_ready_out <= ~next_ob_valid;
      ib_mem <= next_ib_mem;
      ib_wp <= next_ib_wp;
      ib_rp <= next_ib_rp;
      ib_cnt <= next_ib_cnt;
      ib_valid_out <= next_ib_cnt != 2'h0;
      ib_data_out <= next_ib_mem[next_ib_rp];
    end
  end

  // Link outputs come straight from flip-flops.
  assign lnk.rdata = rdata;
  assign lnk.trdy = resp[0];
  assign lnk.stop = resp[1];
  assign lnk.tabort = resp[2];
endmodule : ptfc_target

/* design/ptfc_initiator.sv */
// Purpose: Initiator end: makes the link clock and runs one transfer per request.
// Assumes: Target answers are asynchronous and pass three sampling stages.
// Notes: Frame changes at the falling point of the link clock, the request fields when a request is taken; inputs are read at its rise.
`timescale 1ns/1ps
module ptfc_initiator #(
  parameter int mabort_edges = ptfc_pkg::MABORT_EDGES
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_cmd_in,
  input wire logic [31:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [1:0] done_status_out,
  output logic [31:0] done_rdata_out,
  ptfc_link_if.initiator lnk
);
  typedef enum logic [1:0] {
    I_IDLE = 2'h0,
    I_ADDR = 2'h1,
    I_WAIT = 2'h2,
    I_DROP = 2'h3
  } ptfc_ist_type;

  // The target may wait its full first-data time, so master-abort must come later.
  if (mabort_edges <= ptfc_pkg::FIRST_DATA_EDGES + 2 || mabort_edges > 255) begin : g_bad
    $error("mabort_edges out of range");
  end

  localparam logic [2:0] HALF = 3'(ptfc_pkg::LINK_HALF_CYC - 1);
  logic [2:0] div, next_div;
  logic lclk, next_lclk, rise_pt, fall_pt;
  logic [34:0] s1, s2, s3, filt, next_filt;
  ptfc_ist_type st, next_st;
  logic [7:0] cnt, next_cnt;
  logic frame, next_frame;
  logic [1:0] cmd, next_cmd;
  logic [31:0] addr, next_addr, wdata, next_wdata;
  logic next_done, next_ready;
  logic [1:0] next_status;
  logic [31:0] next_rd;

  // Divider for the link clock; the rise and fall points are one-cycle enables.
  assign rise_pt = (div == HALF) & ~lclk;
  assign fall_pt = (div == HALF) & lclk;
  assign next_div = (div == HALF) ? 3'h0 : div + 3'h1;
  assign next_lclk = (div == HALF) ? ~lclk : lclk;
  assign next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);

  // Request sequencing with a four-phase answer handshake.
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_frame = frame;
    next_cmd = cmd;
    next_addr = addr;
    next_wdata = wdata;
    next_done = 1'b0;
    next_ready = 1'b0;
    next_status = done_status_out;
    next_rd = done_rdata_out;
    case (st)
      I_IDLE: begin
        next_ready = 1'b1;
        if (req_valid_in && req_ready_out) begin
          next_ready = 1'b0;
          next_cmd = req_cmd_in;
          next_addr = req_addr_in;
          next_wdata = req_wdata_in;
          next_st = I_ADDR;
        end
      end
      I_ADDR: begin
        if (fall_pt) begin
          next_frame = 1'b1;
          next_cnt = 8'h00;
          next_st = I_WAIT;
        end
      end
      I_WAIT: begin
        if (rise_pt) begin
          next_cnt = cnt + 8'h01;
          if (filt[34]) begin
            next_status = ptfc_pkg::END_TABORT;
            next_st = I_DROP;
          end else if (filt[32]) begin
            next_status = ptfc_pkg::END_OK;
            next_rd = filt[31:0];
            next_st = I_DROP;
          end else if (filt[33]) begin
            next_status = ptfc_pkg::END_RETRY;
            next_st = I_DROP;
          end else if (cnt == 8'(mabort_edges - 1)) begin
            next_status = ptfc_pkg::END_MABORT;
            next_st = I_DROP;
          end
        end
      end
      I_DROP: begin
        if (fall_pt) begin
          next_frame = 1'b0;
        end
        if (rise_pt && !frame && filt[34:32] == 3'b000) begin
          next_done = 1'b1;
          next_st = I_IDLE;
        end
      end
      default: begin
        next_st = I_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div <= 3'h0;
      lclk <= 1'b0;
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
      st <= I_IDLE;
      cnt <= 8'h00;
      frame <= 1'b0;
      cmd <= 2'h0;
      addr <= 32'h0000_0000;
      wdata <= 32'h0000_0000;
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
      done_status_out <= 2'h0;
      done_rdata_out <= 32'h0000_0000;
    end else begin
      div <= next_div;
      lclk <= next_lclk;
      s1 <= {lnk.tabort, lnk.stop, lnk.trdy, lnk.rdata};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      st <= next_st;
      cnt <= next_cnt;
      frame <= next_frame;
      cmd <= next_cmd;
      addr <= next_addr;
      wdata <= next_wdata;
      req_ready_out <= next_ready;
      done_out <= next_done;
      done_status_out <= next_status;
      done_rdata_out <= next_rd;
    end
  end

  // Link outputs come straight from flip-flops.
  assign lnk.link_clk = lclk;
  assign lnk.frame = frame;
  assign lnk.cmd = cmd;
  assign lnk.addr = addr;
  assign lnk.wdata = wdata;
endmodule : ptfc_initiator

/* tb/ptfc_link_sva.sv */
// Purpose: Protocol checks on the link between initiator and target.
// Assumes: All link signals are sampled by the 40 MHz system clock.
// Notes: Both parties are design modules, so every check watches design outputs.
`timescale 1ns/1ps
module ptfc_link_sva (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic link_clk,
  input wire logic frame,
  input wire logic [1:0] cmd,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic trdy,
  input wire logic stop,
  input wire logic tabort
);
  // One domain, so clock and reset are given once for every check.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  chk_abort_no_data: assert property (tabort |-> !trdy && !stop)
    else $error("target abort shown together with data or stop");
  chk_resp_steady: assert property (frame && $past(frame) && $past(trdy || stop || tabort)
    |-> $stable({trdy, stop, tabort})) else $error("response changed inside a frame");
  chk_rdata_steady: assert property (trdy && $past(trdy) |-> $stable(rdata))
    else $error("read data moved while data ready was shown");
  chk_resp_drop: assert property ($fell(frame) |-> ##[1:24] !(trdy || stop || tabort))
    else $error("response not withdrawn after frame fell");
  chk_resp_in_frame: assert property ($rose(trdy || stop || tabort) |-> frame)
    else $error("response raised outside a frame");
  chk_req_steady: assert property (frame && !(trdy || stop || tabort)
    |=> $stable({cmd, addr, wdata})) else $error("request changed before an answer");
  chk_link_half: assert property ($changed(link_clk) |=> $stable(link_clk) [*3])
    else $error("link clock half period shorter than four cycles");
  chk_no_stale: assert property ($rose(frame) |-> !(trdy || stop || tabort))
    else $error("stale response at start of frame");
  chk_fall_late: assert property ($fell(trdy || stop || tabort) |-> !frame)
    else $error("response withdrawn while frame still high");
endmodule : ptfc_link_sva

/* tb/testbench.sv */
// Purpose: Drives both link ends through APB and host requests and checks the results.
// Assumes: A short first-data count keeps the run brief.
// Notes: Expected values come from the package constants and fixed tables.
`timescale 1ns/1ps
module testbench;
  localparam int FDE = 4;
  logic clk_sys_in = 1'b0, resetn_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, ob_data_in = 32'h0, req_addr_in = 32'h0, req_wdata_in = 32'h0;
  logic ob_valid_in = 1'b0, ib_ready_in = 1'b0, req_valid_in = 1'b0;
  logic [1:0] req_cmd_in = 2'h0;
  logic [31:0] prdata_out, ib_data_out, done_rdata_out, rd_word, xrd;
  logic pready_out, pslverr_out, ob_ready_out, ib_valid_out, req_ready_out, done_out, err_bit;
  logic [1:0] done_status_out;
  int n_mismatch = 0, comparisons = 0, lat, t_fast;
  logic [31:0] tc_tab [6] = '{32'h000c_c000, 32'h0000_c000, 32'h0008_c000, 32'h000e_c000,
                             32'h000a_c000, 32'h000c_c000};
  logic [31:0] bl_tab [6] = '{32'h00, 32'h00, 32'h40, 32'h80, 32'h40, 32'ha0};
  logic cf_tab [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  // The system clock; the link clock is made by the initiator.
  always #12.5 clk_sys_in = ~clk_sys_in;
  ptfc_link_if ptfc_link_if_i ();
  ptfc_target #(.first_data_edges(FDE)) ptfc_target_i (.clk_sys_in, .resetn_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .ob_valid_in, .ob_data_in, .ob_ready_out, .ib_valid_out, .ib_data_out, .ib_ready_in,
    .lnk(ptfc_link_if_i));
  ptfc_initiator ptfc_initiator_i (.clk_sys_in, .resetn_in,
    .req_valid_in, .req_cmd_in, .req_addr_in, .req_wdata_in, .req_ready_out, .done_out,
    .done_status_out, .done_rdata_out, .lnk(ptfc_link_if_i));
  ptfc_link_sva ptfc_link_sva_i (.clk_sys_in, .resetn_in, .link_clk(ptfc_link_if_i.link_clk),
    .frame(ptfc_link_if_i.frame), .cmd(ptfc_link_if_i.cmd), .addr(ptfc_link_if_i.addr),
    .wdata(ptfc_link_if_i.wdata), .rdata(ptfc_link_if_i.rdata), .trdy(ptfc_link_if_i.trdy),
    .stop(ptfc_link_if_i.stop), .tabort(ptfc_link_if_i.tabort));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready_out !== 1'b1);
    rd_word = prdata_out;
    err_bit = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("register word", rd_word, exp);
  endtask : rdchk

  // One host request; the status is taken at the edge that shows done.
  task automatic xfer(input logic [1:0] c, input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] st);
    int n;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_cmd_in <= c;
    req_addr_in <= a;
    req_wdata_in <= d;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (req_ready_out !== 1'b1);
    req_valid_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (done_out !== 1'b1);
    xrd = done_rdata_out;
    lat = n;
    check("done status", {30'h0, done_status_out}, {30'h0, st});
  endtask : xfer

  task automatic offer(input logic [31:0] d);
    @(posedge clk_sys_in);
    ob_valid_in <= 1'b1;
    ob_data_in <= d;
    do begin
      @(posedge clk_sys_in);
    end while (ob_ready_out !== 1'b1);
    ob_valid_in <= 1'b0;
  endtask : offer

  // Takes one inbound word; the drain is stalled outside this task.
  task automatic take(input logic [31:0] exp);
    @(posedge clk_sys_in);
    check("inbound word", ib_data_out, exp);
    check("inbound valid", {31'h0, ib_valid_out}, 32'h1);
    ib_ready_in <= 1'b1;
    @(posedge clk_sys_in);
    ib_ready_in <= 1'b0;
  endtask : take

  task automatic give_verdict();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    n_mismatch++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rdchk(ptfc_pkg::REG_TCTL, ptfc_pkg::TCTL_RST);
    rdchk(ptfc_pkg::REG_MEM_BASE, ptfc_pkg::WORD_RST);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", {31'h0, err_bit}, 32'h1);
    apb(1'b1, ptfc_pkg::REG_MEM_SIZE, 32'h0000_0100);
    apb(1'b1, ptfc_pkg::REG_MEM_BASE, 32'h0000_1000);
    apb(1'b1, ptfc_pkg::REG_IO_SIZE, 32'h0000_0100);
    apb(1'b1, ptfc_pkg::REG_IO_BASE, 32'h0000_2000);
    rdchk(ptfc_pkg::REG_IO_BASE, 32'h0000_2000);
    xfer(ptfc_pkg::CMD_CFG_WR, 32'h0, 32'hffa5_5a00, ptfc_pkg::END_OK);
    rdchk(ptfc_pkg::REG_CFG, 32'hffa5_5a00);
    $display("test reset and setup done");
    offer(32'h1234_5678);
    xfer(ptfc_pkg::CMD_MEM_RD, 32'h0000_1000, 32'h0, ptfc_pkg::END_OK);
    check("read data", xrd, 32'h1234_5678);
    xfer(ptfc_pkg::CMD_MEM_RD, 32'h0000_1000, 32'h0, ptfc_pkg::END_RETRY);
    t_fast = lat;
    apb(1'b1, ptfc_pkg::REG_TCTL, ptfc_pkg::TCTL_RST | 32'h0001_0000);
    xfer(ptfc_pkg::CMD_MEM_RD, 32'h0000_1000, 32'h0, ptfc_pkg::END_RETRY);
    check("retry wait", {31'h0, lat >= t_fast + FDE * ptfc_pkg::LINK_HALF_CYC}, 32'h1);
    // With caching on the word is served again and not consumed.
    apb(1'b1, ptfc_pkg::REG_TCTL, 32'h0004_c000);
    offer(32'h0bad_cafe);
    repeat (2) begin
      xfer(ptfc_pkg::CMD_MEM_RD, 32'h0000_1008, 32'h0, ptfc_pkg::END_OK);
      check("cached data", xrd, 32'h0bad_cafe);
    end
    check("entry kept", {31'h0, ob_ready_out}, 32'h0);
    apb(1'b1, ptfc_pkg::REG_TCTL, ptfc_pkg::TCTL_RST);
    xfer(ptfc_pkg::CMD_MEM_RD, 32'h0000_1008, 32'h0, ptfc_pkg::END_OK);
    check("uncached data", xrd, 32'h0bad_cafe);
    $display("test outbound reads done");
    // The inbound buffer fills while the drain stalls, then empties in order.
    xfer(ptfc_pkg::CMD_MEM_WR, 32'h0000_1004, 32'h1111_0001, ptfc_pkg::END_OK);
    xfer(ptfc_pkg::CMD_IO_WR, 32'h0000_2008, 32'h2222_0002, ptfc_pkg::END_OK);
    xfer(ptfc_pkg::CMD_MEM_WR, 32'h0000_1008, 32'h3333_0003, ptfc_pkg::END_RETRY);
    take(32'h1111_0001);
    take(32'h2222_0002);
    repeat (2) @(posedge clk_sys_in);
    check("inbound empty", {31'h0, ib_valid_out}, 32'h0);
    xfer(ptfc_pkg::CMD_MEM_WR, 32'h0000_10f0, 32'h0, ptfc_pkg::END_TABORT);
    xfer(ptfc_pkg::CMD_MEM_RD, 32'h0000_10fc, 32'h0, ptfc_pkg::END_TABORT);
    xfer(ptfc_pkg::CMD_MEM_WR, 32'h0000_8000, 32'h0, ptfc_pkg::END_MABORT);
    $display("test writes and aborts done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ptfc_pkg::REG_TCTL, tc_tab[i]);
      apb(1'b1, ptfc_pkg::REG_TBL, bl_tab[i]);
      apb(1'b0, ptfc_pkg::REG_STAT, 32'h0);
      check("conflict flag", {31'h0, rd_word[5]}, {31'h0, cf_tab[i]});
    end
    $display("test setting conflicts done");
    give_verdict();
  end
endmodule : testbench
